// >>> include/hv_status_consts.svh
`ifndef HV_STATUS_CONSTS_SVH
`define HV_STATUS_CONSTS_SVH

// ----------------------------------------------------------------
// live status bit positions
// ----------------------------------------------------------------
`define HV_LIVE_WAKE_RB 7
`define HV_LIVE_OVERTEMP 6
`define HV_LIVE_AUX_RB 5
`define HV_LIVE_BUF_EN 4
`define HV_LIVE_LVF 3
`define HV_LIVE_BUS_SHORT 2
`define HV_LIVE_AUX_SHORT 1
`define HV_LIVE_WAKE_SHORT 0

// ----------------------------------------------------------------
// configuration bit positions
// ----------------------------------------------------------------
`define HV_CFG0_LVF_EN 2
`define HV_CFG1_DRV_REARM 3
`define HV_CFG1_READBACK 4

// ----------------------------------------------------------------
// command codes on the command port
// ----------------------------------------------------------------
`define HV_CMD_READ_LIVE 4'h0
`define HV_CMD_READ_CHANGE 4'h1
`define HV_CMD_WRITE_CFG0 4'h2
`define HV_CMD_WRITE_CFG1 4'h3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define HV_CHANGE_RESET 8'h00
`define HV_LIVE_RESET 8'h00
`define HV_CFG_RESET 8'h00
`define HV_DATA_RESET 8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define HV_CLK_PERIOD_NS 10
`define HV_XFER_TIME_NS 10000
`define HV_XFER_CYCLES (`HV_XFER_TIME_NS / `HV_CLK_PERIOD_NS)
`define HV_XFER_CNT_W 10

`endif

// >>> include/hv_status_pkg.sv
package hv_status_pkg;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   // analog side levels, all asynchronous to ref_clk
   typedef struct packed {
      logic wake_pin;        // external wake pin level
      logic aux_hv_pin;      // external auxiliary pin level
      logic thermal_event;   // thermal shutdown indication
      logic bus_short;       // bus driver short detector
      logic aux_short;       // auxiliary driver short detector
      logic wake_short;      // wake driver short detector
      logic core_supply_low; // core supply below threshold
      logic buffer_en;       // voltage channel input buffer on
   } hv_pins_t;

   // one command on the command port
   typedef struct packed {
      logic [3:0] code;  // operation
      logic [7:0] wdata; // write data for configuration writes
   } hv_cmd_t;

   // transfer engine state
   typedef enum logic {
      XFER_IDLE,
      XFER_BUSY
   } xfer_state_t;

endpackage : hv_status_pkg

// >>> src/hv_pin_sync.sv
`include "hv_status_consts.svh"

// three flop synchroniser per bit; output moves once stages two and three agree
module hv_pin_sync #(
   parameter int WIDTH = 8
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [WIDTH-1:0] raw,
   output logic [WIDTH-1:0] clean
);

   // ----------------------------------------------------------------
   // per bit stages
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic s1; // metastable stage, read only by s2
         logic s2; // second stage
         logic s3; // third stage
         logic next_clean;

         // hold the old level while stages two and three disagree
         always_comb begin
            next_clean = (s2 == s3) ? s3 : clean[i];
         end

         // register stages and filtered level
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               s1 <= 1'b0;
               s2 <= 1'b0;
               s3 <= 1'b0;
               clean[i] <= 1'b0;
            end else if (ce) begin
               s1 <= raw[i];
               s2 <= s1;
               s3 <= s2;
               clean[i] <= next_clean;
            end
         end
      end
   endgenerate

endmodule : hv_pin_sync

// >>> src/hv_status_monitor_regs.sv
`include "hv_status_consts.svh"

// Contract
// RL1 - bit 7 shows wake pin when readback on
// RL2 - bit 6 set after thermal shutdown
// RL3 - bit 5 shows aux pin when readback on
// RL4 - bit 4 mirrors voltage input buffer enable
// RL5 - bit 3 low voltage flag, gated by enable
// RL6 - flag stays zero after a supply drop until re-enabled
// RL7 - bit 2 bus short, cleared by rearm write
// RL8 - bit 1 aux short, cleared by rearm write
// RL9 - bit 0 wake driver short flag
// RL10 - change register records live bit changes
// RL11 - software reads change on interrupt or by read command
// RL12 - interrupt copies change value to data port
// RL13 - both registers reached through command, data ports
// RL14 - busy held about 10 us per transfer
// RL15 - reading change register clears all its bits
// RL16 - change bits stay set until read
module hv_status_monitor_regs
   import hv_status_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic cmd_write,
   input wire hv_cmd_t cmd,
   input wire hv_pins_t pins_raw,
   output logic hv_busy,
   output logic [7:0] hv_data_port,
   output logic hv_interrupt,
   output logic [7:0] hv_config_0,
   output logic [7:0] hv_config_1,
   output logic [7:0] hv_live_status,
   output logic [7:0] hv_change_status
);

   // ----------------------------------------------------------------
   // pin synchronisation
   // ----------------------------------------------------------------
   hv_pins_t pins; // filtered levels on ref_clk

   hv_pin_sync #(
      .WIDTH($bits(hv_pins_t))
   ) u_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .ce(ce),
      .raw(pins_raw),
      .clean(pins)
   );

   // ----------------------------------------------------------------
   // transfer engine and command decode
   // ----------------------------------------------------------------
   xfer_state_t state; // idle or busy
   xfer_state_t next_state;
   logic [`HV_XFER_CNT_W-1:0] xfer_cnt; // cycles spent busy
   logic [`HV_XFER_CNT_W-1:0] next_xfer_cnt;
   logic irq_pending; // change seen while busy
   logic next_irq_pending;
   logic next_busy;
   logic next_interrupt;
   logic [7:0] next_data;
   logic [7:0] next_cfg0;
   logic [7:0] next_cfg1;
   logic cmd_accept; // command taken this cycle
   logic auto_start; // automatic status transfer starts
   logic rd_change; // change register read this cycle
   logic drv_rearm; // rearm write to config 1
   logic lvf_arm; // flag enable written to config 0
   logic [7:0] next_live;
   logic [7:0] next_change;
   logic [7:0] diff; // live bits changing this cycle
   logic rearm_dly; // rearm write taken last cycle, applied to the sticky flags now
   logic lvf_arm_dly; // flag enable written last cycle, arms the flag now

   localparam logic [`HV_XFER_CNT_W-1:0] XFER_LAST = `HV_XFER_CNT_W'(`HV_XFER_CYCLES - 1);

   // next values of the engine; the automatic transfer outranks a command
   always_comb begin
      next_state = state;
      next_xfer_cnt = xfer_cnt;
      next_busy = hv_busy;
      next_interrupt = 1'b0;
      next_data = hv_data_port;
      next_cfg0 = hv_config_0;
      next_cfg1 = hv_config_1;
      next_irq_pending = irq_pending | (|diff);
      auto_start = 1'b0;
      cmd_accept = 1'b0;
      rd_change = 1'b0;
      drv_rearm = 1'b0;
      lvf_arm = 1'b0;
      unique case (state)
         XFER_IDLE: begin
            if (irq_pending || (|diff)) begin
               // status goes out together with the interrupt
               auto_start = 1'b1;
               next_interrupt = 1'b1; // RL12
               // no read clear can fall in this cycle, the automatic transfer wins
               next_data = hv_change_status | diff; // RL12
               next_irq_pending = 1'b0;
            end else if (cmd_write) begin
               cmd_accept = 1'b1;
               unique case (cmd.code)
                  `HV_CMD_READ_LIVE: next_data = hv_live_status; // RL13
                  `HV_CMD_READ_CHANGE: begin
                     next_data = hv_change_status; // RL13
                     rd_change = 1'b1;
                  end
                  `HV_CMD_WRITE_CFG0: begin
                     next_cfg0 = cmd.wdata;
                     lvf_arm = cmd.wdata[`HV_CFG0_LVF_EN];
                  end
                  `HV_CMD_WRITE_CFG1: begin
                     next_cfg1 = cmd.wdata;
                     drv_rearm = cmd.wdata[`HV_CFG1_DRV_REARM];
                  end
                  // unknown codes still occupy the port, nothing else
                  default: next_data = hv_data_port;
               endcase
            end
            if (auto_start || cmd_accept) begin
               next_state = XFER_BUSY;
               next_busy = 1'b1; // RL14
               next_xfer_cnt = '0;
            end
         end
         XFER_BUSY: begin
            // commands arriving now are dropped; software polls busy first
            if (xfer_cnt == XFER_LAST) begin
               next_state = XFER_IDLE;
               next_busy = 1'b0; // RL14
            end else begin
               next_xfer_cnt = xfer_cnt + 1'b1;
            end
         end
      endcase
   end

   // register the engine
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state <= XFER_IDLE;
         xfer_cnt <= '0;
         hv_busy <= 1'b0;
         hv_interrupt <= 1'b0;
         irq_pending <= 1'b0;
         hv_data_port <= `HV_DATA_RESET;
         hv_config_0 <= `HV_CFG_RESET;
         hv_config_1 <= `HV_CFG_RESET;
         rearm_dly <= 1'b0;
         lvf_arm_dly <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         xfer_cnt <= next_xfer_cnt;
         hv_busy <= next_busy;
         hv_interrupt <= next_interrupt;
         irq_pending <= next_irq_pending;
         hv_data_port <= next_data;
         hv_config_0 <= next_cfg0;
         hv_config_1 <= next_cfg1;
         rearm_dly <= drv_rearm;
         lvf_arm_dly <= lvf_arm;
      end
   end

   // ----------------------------------------------------------------
   // live status
   // ----------------------------------------------------------------
   // sticky flags keep the set over a same-cycle rearm so no event is lost
   // config and arm pulses come from registers: the live view must not feed
   // back into the command decode, which itself waits on live changes
   always_comb begin
      next_live = hv_live_status;
      // readback only while enabled; reads zero otherwise
      next_live[`HV_LIVE_WAKE_RB] = hv_config_1[`HV_CFG1_READBACK] & pins.wake_pin; // RL1
      next_live[`HV_LIVE_AUX_RB] = hv_config_1[`HV_CFG1_READBACK] & pins.aux_hv_pin; // RL3
      next_live[`HV_LIVE_BUF_EN] = pins.buffer_en; // RL4
      next_live[`HV_LIVE_OVERTEMP] = pins.thermal_event
         | (hv_live_status[`HV_LIVE_OVERTEMP] & ~rearm_dly); // RL2
      next_live[`HV_LIVE_BUS_SHORT] = pins.bus_short
         | (hv_live_status[`HV_LIVE_BUS_SHORT] & ~rearm_dly); // RL7
      next_live[`HV_LIVE_AUX_SHORT] = pins.aux_short
         | (hv_live_status[`HV_LIVE_AUX_SHORT] & ~rearm_dly); // RL8
      next_live[`HV_LIVE_WAKE_SHORT] = pins.wake_short
         | (hv_live_status[`HV_LIVE_WAKE_SHORT] & ~rearm_dly); // RL9
      // a supply drop beats re-arming: the memory really is suspect then
      if (!hv_config_0[`HV_CFG0_LVF_EN]) begin
         next_live[`HV_LIVE_LVF] = 1'b0; // RL5
      end else if (lvf_arm_dly) begin
         next_live[`HV_LIVE_LVF] = ~pins.core_supply_low; // RL6
      end else begin
         next_live[`HV_LIVE_LVF] = hv_live_status[`HV_LIVE_LVF] & ~pins.core_supply_low; // RL6
      end
   end

   // ----------------------------------------------------------------
   // change status
   // ----------------------------------------------------------------
   // a fresh change beats the clear of a read in the same cycle
   always_comb begin
      diff = next_live ^ hv_live_status; // RL10
      next_change = (hv_change_status & ~{8{rd_change}}) | diff; // RL15 RL16
   end

   // register live and change views
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         hv_live_status <= `HV_LIVE_RESET;
         hv_change_status <= `HV_CHANGE_RESET;
      end else if (ce) begin
         hv_live_status <= next_live;
         hv_change_status <= next_change;
      end
   end

endmodule : hv_status_monitor_regs

// >>> sim/hv_status_monitor_regs_sva.sv
// ----------------------------------------------------------------
// port checker for the status register block
// ----------------------------------------------------------------
module hv_status_monitor_regs_sva
   import hv_status_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic cmd_write,
   input wire hv_cmd_t cmd,
   input wire hv_pins_t pins_raw,
   input wire logic hv_busy,
   input wire logic [7:0] hv_data_port,
   input wire logic hv_interrupt,
   input wire logic [7:0] hv_config_0,
   input wire logic [7:0] hv_config_1,
   input wire logic [7:0] hv_live_status,
   input wire logic [7:0] hv_change_status
);
   logic [10:0] busy_cnt; // busy cycles so far
   logic [10:0] next_busy_cnt;
   // count busy cycles, frozen with the clock enable
   always_comb begin
      next_busy_cnt = hv_busy ? busy_cnt + 11'h001 : 11'h000;
      if (!ce) next_busy_cnt = busy_cnt;
      if (rst) next_busy_cnt = 11'h000;
   end
   always_ff @(posedge ref_clk) begin
      busy_cnt <= next_busy_cnt;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // past term avoids a false fire on the edge the config changes
   AST_RB_WAKE: assert property (!hv_config_1[4] && !$past(hv_config_1[4]) |->
      !hv_live_status[7]) else $error("wake readback while off");
   AST_RB_AUX: assert property (!hv_config_1[4] && !$past(hv_config_1[4]) |->
      !hv_live_status[5]) else $error("aux readback while off");
   AST_LVF_GATE: assert property (!hv_config_0[2] && !$past(hv_config_0[2]) |->
      !hv_live_status[3]) else $error("flag shown while off");
   // the re-arm lands one cycle after busy rises, so only settled busy cycles count
   AST_LVF_HOLD: assert property (hv_busy && $past(hv_busy) && !hv_live_status[3] |=>
      !hv_live_status[3]) else $error("flag came back alone");
   AST_BUSY_RUN: assert property (hv_busy |-> busy_cnt < 11'd1000)
      else $error("busy too long");
   AST_BUSY_END: assert property ($fell(hv_busy) |-> busy_cnt == 11'd1000)
      else $error("busy too short");
   AST_IRQ_DATA: assert property (hv_interrupt |-> hv_busy &&
      hv_data_port == hv_change_status) else $error("change not copied");
   AST_IRQ_PULSE: assert property (hv_interrupt |=> !hv_interrupt)
      else $error("interrupt not a pulse");
   AST_CHG_SET: assert property (((hv_live_status ^ $past(hv_live_status)) &
      ~hv_change_status) == 8'h00) else $error("change bit missed");
   AST_CHG_HOLD: assert property ($past(hv_busy) && hv_busy |->
      (~hv_change_status & $past(hv_change_status)) == 8'h00) else $error("change lost");
   cover property (hv_interrupt);
   cover property ($fell(hv_busy));
   cover property ($rose(hv_live_status[3]));
endmodule : hv_status_monitor_regs_sva

bind hv_status_monitor_regs hv_status_monitor_regs_sva chk_i (.ref_clk(ref_clk), .rst(rst),
   .ce(ce), .cmd_write(cmd_write), .cmd(cmd), .pins_raw(pins_raw), .hv_busy(hv_busy),
   .hv_data_port(hv_data_port), .hv_interrupt(hv_interrupt), .hv_config_0(hv_config_0),
   .hv_config_1(hv_config_1), .hv_live_status(hv_live_status),
   .hv_change_status(hv_change_status));

// >>> sim/tb_hv_status_monitor_regs.sv
module tb_hv_status_monitor_regs;
   timeunit 1ns;
   timeprecision 1ns;
   import hv_status_pkg::*;
   logic ref_clk, rst, ce, cmd_write, hv_busy, hv_interrupt;
   hv_cmd_t cmd;
   hv_pins_t pins_raw;
   logic [7:0] hv_data_port, hv_config_0, hv_config_1, hv_live_status, hv_change_status;
   int num_errors;
   int samples_checked;
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   hv_status_monitor_regs dut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .cmd_write(cmd_write),
      .cmd(cmd), .pins_raw(pins_raw), .hv_busy(hv_busy), .hv_data_port(hv_data_port),
      .hv_interrupt(hv_interrupt), .hv_config_0(hv_config_0), .hv_config_1(hv_config_1),
      .hv_live_status(hv_live_status), .hv_change_status(hv_change_status));
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task final_report;
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : final_report
   // wait until idle long enough for pending pin changes to have run
   task settle;
      int quiet;
      quiet = 0;
      for (int i = 0; i < 5000 && quiet < 12; i++) begin
         @(negedge ref_clk);
         quiet = hv_busy ? 0 : quiet + 1;
      end
      if (quiet < 12) begin
         num_errors++;
         final_report();
      end
   endtask : settle
   // one command, given only when idle so it is never dropped
   task do_cmd(input logic [3:0] code, input logic [7:0] wd);
      settle();
      cmd_write = 1'b1;
      cmd = '{code, wd};
      @(negedge ref_clk);
      cmd_write = 1'b0;
      chk("busy", {7'h00, hv_busy}, 8'h01);
      settle();
   endtask : do_cmd
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task t_auto;
      int n;
      chk("change", hv_change_status, 8'h00);
      pins_raw.buffer_en = 1'b1;
      for (n = 0; n < 12 && hv_interrupt !== 1'b1; n++) @(negedge ref_clk);
      if (hv_interrupt !== 1'b1) begin
         num_errors++;
         final_report();
      end
      chk("irq", {7'h00, hv_interrupt}, 8'h01);
      chk("data", hv_data_port, 8'h10);
      chk("live", hv_live_status, 8'h10);
      chk("change", hv_change_status, 8'h10);
      // busy must stand for the whole transfer time, 1000 cycles
      for (n = 0; n < 1100 && hv_busy === 1'b1; n++) @(negedge ref_clk);
      chk("busy cycles hi", 8'(n >> 8), 8'h03);
      chk("busy cycles lo", 8'(n), 8'hE8);
      do_cmd(4'h1, 8'h00);
      chk("data", hv_data_port, 8'h10);
      chk("change", hv_change_status, 8'h00);
   endtask : t_auto
   task t_sticky;
      {pins_raw.thermal_event, pins_raw.bus_short, pins_raw.aux_short} = 3'b111;
      pins_raw.wake_short = 1'b1;
      settle();
      {pins_raw.thermal_event, pins_raw.bus_short, pins_raw.aux_short} = 3'b000;
      pins_raw.wake_short = 1'b0;
      settle();
      chk("live", hv_live_status, 8'h57);
      chk("aux short", {7'h00, hv_live_status[1]}, 8'h01);
      chk("wake short", {7'h00, hv_live_status[0]}, 8'h01);
      do_cmd(4'h1, 8'h00);
      chk("data", hv_data_port, 8'h47);
      do_cmd(4'h3, 8'h08);
      chk("cfg1", hv_config_1, 8'h08);
      chk("live", hv_live_status, 8'h10);
   endtask : t_sticky
   task t_readback;
      {pins_raw.wake_pin, pins_raw.aux_hv_pin} = 2'b11;
      settle();
      chk("live", hv_live_status, 8'h10);
      do_cmd(4'h3, 8'h10);
      chk("live", hv_live_status, 8'hB0);
      do_cmd(4'h0, 8'h00);
      chk("data", hv_data_port, 8'hB0);
   endtask : t_readback
   task t_lvf;
      do_cmd(4'h2, 8'h04);
      chk("cfg0", hv_config_0, 8'h04);
      chk("live", hv_live_status, 8'hB8);
      pins_raw.core_supply_low = 1'b1;
      settle();
      pins_raw.core_supply_low = 1'b0;
      settle();
      chk("live", hv_live_status, 8'hB0);
      do_cmd(4'h2, 8'h04);
      chk("live", hv_live_status, 8'hB8);
   endtask : t_lvf
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      cmd_write = 1'b0;
      cmd = '0;
      pins_raw = '0;
      num_errors = 0;
      samples_checked = 0;
      repeat (12) @(negedge ref_clk);
      rst = 1'b0;
      t_auto();
      t_sticky();
      t_readback();
      t_lvf();
      final_report();
   end
endmodule : tb_hv_status_monitor_regs
